// file: field_src.sv
// Behavioural sensors and contacts on the counter's field pins
`timescale 1ns/10ps
`default_nettype none

module field_src (
  // Clock
  input wire logic clk,
  // Field pins
  output logic cnt_a,
  output logic cnt_b,
  output logic rst_a,
  output logic rst_b,
  output logic key
);
  initial begin
    cnt_a = 1'b0;
    cnt_b = 1'b0;
    rst_a = 1'b0;
    rst_b = 1'b0;
    key = 1'b0;
  end

  // pulses high and low 4 cycles
  task automatic pulse(input logic a, input logic b);
    @(posedge clk);
    cnt_a <= a;
    cnt_b <= b;
    repeat (4) @(posedge clk);
    cnt_a <= 1'b0;
    cnt_b <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // Reset contact levels
  task automatic level(input logic ra, input logic rb);
    @(posedge clk);
    rst_a <= ra;
    rst_b <= rb;
    repeat (4) @(posedge clk);
  endtask

  // Operator key press
  task automatic press();
    @(posedge clk);
    key <= 1'b1;
    repeat (4) @(posedge clk);
    key <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
endmodule // field_src

`default_nettype wire

// file: input_edge.sv
// Two-stage pin synchroniser with rising-edge detector
`timescale 1ns/10ps
`default_nettype none

module input_edge (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pin side
  input wire logic pin,
  // Conditioned side
  output logic level,
  output logic rise
);
  logic meta_r;
  logic sync_r;
  logic last_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_r <= 1'h0;
      sync_r <= 1'h0;
      last_r <= 1'h0;
    end else begin
      meta_r <= pin;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign level = sync_r;
  assign rise = sync_r & ~last_r;

  rise_single_a: assert property (@(posedge clk) disable iff (!rst_n)
    rise |=> !rise)
    else $error("edge pulse longer than one cycle");
endmodule // input_edge

`default_nettype wire

// file: mpc_pkg.sv
// Package: constants and types for the multimode preset counter
package mpc_pkg;
  // ----------------------------------------
  // Ranges
  // ----------------------------------------
  localparam logic [19:0] CNT_MAX = 20'hF423F;
  localparam logic [19:0] CNT_ZERO = 20'h00000;
  localparam logic signed [20:0] SET_MAX = 21'sh0F423F;
  localparam logic signed [20:0] SET_MIN = 21'sh1E7961;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int SHOT_UNIT_NS = 10000000;
  localparam int TICK_CYCLES = SHOT_UNIT_NS / CLK_PERIOD_NS;
  localparam logic [13:0] SHOT_MIN = 14'h0001;
  localparam logic [13:0] SHOT_MAX = 14'h270F;
  // ----------------------------------------
  // Configurations and display selection
  // ----------------------------------------
  typedef enum logic [5:0] {
    CFG_ONE = 6'h01,
    CFG_TWO = 6'h02,
    CFG_TOTAL = 6'h04,
    CFG_BATCH = 6'h08,
    CFG_DUAL = 6'h10,
    CFG_TWIN = 6'h20
  } cfg_type;
  typedef enum logic [4:0] {
    DSP_PRESENT = 5'h01,
    DSP_TOTAL = 5'h02,
    DSP_BATCH = 5'h04,
    DSP_DUAL = 5'h08,
    DSP_SECOND = 5'h10
  } disp_type;
  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    cfg_type cfg;
    logic calc_sub;
    logic oneshot_en;
    logic [13:0] oneshot_time;
    logic backup_en;
  } settings_type;
  typedef struct packed {
    logic signed [20:0] set1;
    logic signed [20:0] set2;
    logic signed [20:0] dual_set;
    logic [19:0] batch_set;
  } setvals_type;
  localparam setvals_type SETV_RESET = '{
    set1: SET_MAX, set2: SET_MAX, dual_set: SET_MAX, batch_set: CNT_ZERO};
endpackage

// file: multimode_preset_counter.sv
// Counting core of a multimode preset counter
`timescale 1ns/10ps
`default_nettype none

// Contract
// - Outside dual, present tally wraps to zero past 999999; in dual it halts.
// - First reset blocks counts, holds tally zero.
// - First reset ends an active one-shot pulse, except in dual and twin.
// - Backup restores outputs; one-shot restarts fully.
// - Joined configurations drive both outputs together.
// - Set values accepted from -99999 to 999999.
// - Total survives first reset, holds during it.
// - Second reset clears total in total mode.
// - Key on total display clears total, tally.
// - Total wraps to zero at full scale.
// - Completions count batches; output at match.
// - Batch reset clears, drops and holds batch.
// - Key on batch display clears batch, tally.
// - Zero batch set value never drives output.
// - Batch wraps at 999999; 5 kHz rate.
// - Lowered batch set asserts; raising keeps output.
// - Dual value is sum or difference.
// - Dual match drives outputs per output mode.
// - Each reset freezes only its own channel.
// - Key in dual clears all, outputs off.
// - Dual out of range flags and halts counting.
// - Twin mode runs two independent up counters.
// - One-shot length 0.01 to 99.99 seconds.
module multimode_preset_counter #(
  parameter int TICK_CYCLES = mpc_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Field inputs
  input wire logic count_input_a,
  input wire logic count_input_b,
  input wire logic reset_a_in,
  input wire logic reset_b_in,
  input wire logic reset_key_in,
  // Configuration
  input wire mpc_pkg::settings_type settings,
  input wire mpc_pkg::setvals_type set_values,
  input wire logic set_load,
  input wire mpc_pkg::disp_type display_sel,
  // Power restore
  input wire logic restore_pulse,
  input wire logic restore_first_control_output,
  input wire logic restore_second_control_output,
  // Outputs
  output logic first_control_output,
  output logic second_control_output,
  output logic [19:0] present_tally,
  output logic [19:0] present_tally_b,
  output logic [19:0] total_tally,
  output logic [19:0] batch_tally,
  output logic signed [21:0] dual_tally,
  output logic overflow,
  output logic set_reject
);
  localparam int DIV_W = $clog2(TICK_CYCLES + 1);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [19:0] inc_wrap(input logic [19:0] v);
    inc_wrap = (v == mpc_pkg::CNT_MAX) ? mpc_pkg::CNT_ZERO : v + 20'h00001;
  endfunction

  function automatic logic signed [20:0] to_s(input logic [19:0] v);
    to_s = signed'({1'h0, v});
  endfunction

  function automatic logic in_range(input logic signed [20:0] v);
    in_range = (v >= mpc_pkg::SET_MIN) && (v <= mpc_pkg::SET_MAX);
  endfunction

  function automatic logic [13:0] shot_len(input logic [13:0] v);
    if (v < mpc_pkg::SHOT_MIN) begin
      shot_len = mpc_pkg::SHOT_MIN;
    end else if (v > mpc_pkg::SHOT_MAX) begin
      shot_len = mpc_pkg::SHOT_MAX;
    end else begin
      shot_len = v;
    end
  endfunction

  // ----------------------------------------
  // Input conditioning
  // ----------------------------------------
  logic a_rise, b_rise, rst_a, rst_b, key_rise;

  input_edge u_cnt_a (.clk(clk), .rst_n(rst_n), .pin(count_input_a), .level(), .rise(a_rise));
  input_edge u_cnt_b (.clk(clk), .rst_n(rst_n), .pin(count_input_b), .level(), .rise(b_rise));
  input_edge u_rst_a (.clk(clk), .rst_n(rst_n), .pin(reset_a_in), .level(rst_a), .rise());
  input_edge u_rst_b (.clk(clk), .rst_n(rst_n), .pin(reset_b_in), .level(rst_b), .rise());
  input_edge u_key (.clk(clk), .rst_n(rst_n), .pin(reset_key_in), .level(), .rise(key_rise));

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic is_one, is_two, is_total, is_batch, is_dual, is_twin, joined, uses_b, sel_b;
  logic key_a, key_b, key_total, key_batch, backup_go;

  assign is_one = settings.cfg == mpc_pkg::CFG_ONE;
  assign is_two = settings.cfg == mpc_pkg::CFG_TWO;
  assign is_total = settings.cfg == mpc_pkg::CFG_TOTAL;
  assign is_batch = settings.cfg == mpc_pkg::CFG_BATCH;
  assign is_dual = settings.cfg == mpc_pkg::CFG_DUAL;
  assign is_twin = settings.cfg == mpc_pkg::CFG_TWIN;
  assign joined = is_one | is_total | is_dual;
  assign uses_b = is_dual | is_twin;
  assign sel_b = display_sel == mpc_pkg::DSP_SECOND;
  assign key_a = key_rise & ~(is_twin & sel_b);
  assign key_b = key_rise & (is_dual | (is_twin & sel_b));
  assign key_total = key_rise & is_total & (display_sel == mpc_pkg::DSP_TOTAL);
  assign key_batch = key_rise & is_batch & (display_sel == mpc_pkg::DSP_BATCH);
  assign backup_go = restore_pulse & settings.backup_en;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [19:0] tally_a_r, tally_b_r, total_r, batch_r, nxt_a, nxt_b;
  logic signed [21:0] dual_r, dual_nxt;
  mpc_pkg::setvals_type setv_r;
  logic reject_r, halt_r, main_r, first_control_output_r, batch_out_r;
  logic [13:0] shot_r;
  logic [DIV_W-1:0] div_r;
  logic inc_a, inc_b, ovf_a, ovf_b, dual_bad, dual_hit;
  logic hit_a1, hit_a2, hit_b2, main_set, ext_clr, shot_end, div_last, shot_start;

  // ----------------------------------------
  // Set values
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      setv_r <= mpc_pkg::SETV_RESET;
      reject_r <= 1'h0;
    end else if (set_load) begin
      if (in_range(set_values.set1) && in_range(set_values.set2) &&
          in_range(set_values.dual_set) && (set_values.batch_set <= mpc_pkg::CNT_MAX)) begin
        setv_r <= set_values;
        reject_r <= 1'h0;
      end else begin
        reject_r <= 1'h1;
      end
    end
  end

  // ----------------------------------------
  // Count enables
  // ----------------------------------------
  // counts blocked in reset
  assign inc_a = a_rise & ~rst_a & ~halt_r;
  assign inc_b = b_rise & ~rst_b & ~halt_r & uses_b;
  assign nxt_a = inc_wrap(tally_a_r);
  assign nxt_b = inc_wrap(tally_b_r);
  assign ovf_a = is_dual & inc_a & (tally_a_r == mpc_pkg::CNT_MAX);
  assign ovf_b = is_dual & inc_b & (tally_b_r == mpc_pkg::CNT_MAX);

  // ----------------------------------------
  // Channel tallies
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tally_a_r <= mpc_pkg::CNT_ZERO;
    end else if (rst_a | key_a) begin
      tally_a_r <= mpc_pkg::CNT_ZERO;
    end else if (inc_a & ~ovf_a) begin
      tally_a_r <= nxt_a;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tally_b_r <= mpc_pkg::CNT_ZERO;
    end else if ((rst_b & uses_b) | key_b) begin
      tally_b_r <= mpc_pkg::CNT_ZERO;
    end else if (inc_b & ~ovf_b) begin
      tally_b_r <= nxt_b;
    end
  end

  // ----------------------------------------
  // Total counter
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      total_r <= mpc_pkg::CNT_ZERO;
    end else if ((rst_b & is_total) | key_total) begin
      total_r <= mpc_pkg::CNT_ZERO;
    end else if (is_total & inc_a) begin
      total_r <= inc_wrap(total_r);
    end
  end

  // ----------------------------------------
  // Dual value and range guard
  // ----------------------------------------
  // sum or difference
  always_comb begin
    if (settings.calc_sub) begin
      dual_nxt = $signed({2'h0, tally_a_r}) - $signed({2'h0, tally_b_r});
    end else begin
      dual_nxt = $signed({2'h0, tally_a_r}) + $signed({2'h0, tally_b_r});
    end
  end

  assign dual_bad = (dual_nxt > 22'(mpc_pkg::SET_MAX)) | (dual_nxt < 22'(mpc_pkg::SET_MIN));
  // match on a fresh dual value
  assign dual_hit = is_dual & ~halt_r & (dual_nxt == 22'(setv_r.dual_set)) &
                    (dual_r != dual_nxt);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dual_r <= 22'h000000;
    end else begin
      dual_r <= dual_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      halt_r <= 1'h0;
    end else if (is_dual & ~key_rise & (ovf_a | ovf_b | dual_bad)) begin
      halt_r <= 1'h1;
    end else if (key_rise | ~is_dual) begin
      halt_r <= 1'h0;
    end
  end

  // ----------------------------------------
  // Completion events
  // ----------------------------------------
  assign hit_a1 = inc_a & (to_s(nxt_a) == setv_r.set1);
  assign hit_a2 = inc_a & (to_s(nxt_a) == setv_r.set2);
  assign hit_b2 = inc_b & (to_s(nxt_b) == setv_r.set2);
  assign main_set = is_dual ? dual_hit : (is_twin ? hit_b2 : hit_a2);
  assign ext_clr = is_twin ? (key_b | rst_b) : (key_rise | (rst_a & ~is_dual));
  assign div_last = div_r == DIV_W'(TICK_CYCLES - 1);
  assign shot_end = settings.oneshot_en & main_r & (shot_r == 14'h0001) & div_last;
  assign shot_start = settings.oneshot_en & (main_set | (backup_go & restore_second_control_output));

  // ----------------------------------------
  // One-shot timer
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shot_r <= 14'h0000;
      div_r <= '0;
    end else if (shot_start) begin
      shot_r <= shot_len(settings.oneshot_time);
      div_r <= '0;
    end else if (ext_clr | ~settings.oneshot_en) begin
      shot_r <= 14'h0000;
      div_r <= '0;
    end else if (shot_r != 14'h0000) begin
      if (div_last) begin
        div_r <= '0;
        shot_r <= shot_r - 14'h0001;
      end else begin
        div_r <= div_r + DIV_W'(1);
      end
    end
  end

  // ----------------------------------------
  // Control outputs
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      main_r <= 1'h0;
    end else if (backup_go) begin
      main_r <= restore_second_control_output;
    end else if (main_set) begin
      main_r <= 1'h1;
    end else if (ext_clr | shot_end) begin
      main_r <= 1'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      first_control_output_r <= 1'h0;
    end else if (backup_go) begin
      first_control_output_r <= restore_first_control_output;
    end else if ((is_two | is_twin) & hit_a1) begin
      first_control_output_r <= 1'h1;
    end else if (is_twin ? (key_a | rst_a) : (key_rise | rst_a)) begin
      first_control_output_r <= 1'h0;
    end
  end

  // ----------------------------------------
  // Batch counter
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      batch_r <= mpc_pkg::CNT_ZERO;
    end else if ((rst_b & is_batch) | key_batch) begin
      batch_r <= mpc_pkg::CNT_ZERO;
    end else if (is_batch & hit_a2) begin
      batch_r <= inc_wrap(batch_r);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      batch_out_r <= 1'h0;
    end else if (backup_go & is_batch) begin
      batch_out_r <= restore_first_control_output;
    end else if ((rst_b & is_batch) | key_batch) begin
      batch_out_r <= 1'h0;
    end else if (is_batch & (setv_r.batch_set != mpc_pkg::CNT_ZERO) &
                 (batch_r >= setv_r.batch_set)) begin
      batch_out_r <= 1'h1;
    end
  end

  // ----------------------------------------
  // Output drive
  // ----------------------------------------
  // joined outputs
  assign first_control_output = is_batch ? batch_out_r : (joined ? main_r : first_control_output_r);
  assign second_control_output = main_r;
  assign present_tally = tally_a_r;
  assign present_tally_b = tally_b_r;
  assign total_tally = total_r;
  assign batch_tally = batch_r;
  assign dual_tally = dual_r;
  assign overflow = halt_r;
  assign set_reject = reject_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  tally_wrap_a: assert property (
    (tally_a_r == mpc_pkg::CNT_MAX) && inc_a && !is_dual && !key_a |=> tally_a_r == 20'h00000)
    else $error("tally did not wrap to zero");
  reset_hold_a: assert property (
    rst_a [*2] |-> tally_a_r == 20'h00000)
    else $error("tally not held during first reset");
  shot_cut_a: assert property (
    rst_a && !is_dual && !is_twin && !backup_go |=> !main_r)
    else $error("output survived first reset");
  restore_on_a: assert property (
    backup_go && restore_second_control_output |=> main_r ##0 (shot_r == shot_len($past(settings.oneshot_time))
      || !settings.oneshot_en))
    else $error("restore did not restart output");
  joint_out_a: assert property (
    joined |-> first_control_output == second_control_output)
    else $error("joined outputs differ");
  set_guard_a: assert property (
    set_load && !in_range(set_values.set2) |=> $stable(setv_r) && set_reject)
    else $error("out of range set value taken");
  total_keep_a: assert property (
    is_total && rst_a && !rst_b && !key_rise |=> $stable(total_r))
    else $error("total moved during first reset");
  total_clear_a: assert property (
    is_total && rst_b |=> total_r == 20'h00000)
    else $error("total not cleared by second reset");
  batch_zero_a: assert property (
    is_batch && rst_b && !restore_pulse |=> batch_r == 20'h00000 && !batch_out_r)
    else $error("batch not held clear");
  dual_halt_a: assert property (
    halt_r |-> !inc_a && !inc_b)
    else $error("counting while halted");

  main_fire_c: cover property (main_set ##1 main_r);
  shot_done_c: cover property (shot_end ##1 !main_r);
  batch_fire_c: cover property ($rose(batch_out_r));
  halt_seen_c: cover property ($rose(halt_r));
endmodule // multimode_preset_counter

`default_nettype wire

// file: tb_top.sv
// Self-checking testbench of the multimode preset counter
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ca, cb, ra, rb, rk;
  mpc_pkg::settings_type settings;
  mpc_pkg::setvals_type set_values;
  logic set_load = 1'b0;
  mpc_pkg::disp_type display_sel = mpc_pkg::DSP_PRESENT;
  logic restore_pulse = 1'b0;
  logic restore_first_control_output = 1'b0;
  logic restore_second_control_output = 1'b0;
  logic o1, o2, ovf, rej;
  logic [19:0] pa, pb, tot, bat;
  logic signed [21:0] dual;
  int err_count = 0;
  int checks_done = 0;

  always #12.5 clk = ~clk;

  field_src src (.clk(clk), .cnt_a(ca), .cnt_b(cb), .rst_a(ra), .rst_b(rb), .key(rk));

  multimode_preset_counter #(.TICK_CYCLES(4)) DUT (
    .clk(clk), .rst_n(rst_n), .count_input_a(ca), .count_input_b(cb),
    .reset_a_in(ra), .reset_b_in(rb), .reset_key_in(rk), .settings(settings),
    .set_values(set_values), .set_load(set_load), .display_sel(display_sel),
    .restore_pulse(restore_pulse), .restore_first_control_output(restore_first_control_output),
    .restore_second_control_output(restore_second_control_output), .first_control_output(o1),
    .second_control_output(o2), .present_tally(pa), .present_tally_b(pb),
    .total_tally(tot), .batch_tally(bat), .dual_tally(dual), .overflow(ovf),
    .set_reject(rej));

  task automatic chk(input logic [21:0] got, input logic [21:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cfg(input mpc_pkg::cfg_type c, input logic s, input logic os);
    @(posedge clk);
    settings <= '{cfg: c, calc_sub: s, oneshot_en: os, oneshot_time: 14'h0003,
      backup_en: 1'b1};
    repeat (2) @(posedge clk);
  endtask

  task automatic load(input logic signed [20:0] s1, input logic signed [20:0] s2,
                      input logic signed [20:0] ds, input logic [19:0] bs);
    @(posedge clk);
    set_values <= '{set1: s1, set2: s2, dual_set: ds, batch_set: bs};
    set_load <= 1'b1;
    @(posedge clk);
    set_load <= 1'b0;
    @(posedge clk);
  endtask

  task automatic t_oneshot();
    cfg(mpc_pkg::CFG_ONE, 1'b0, 1'b1);
    load(21'sh000001, 21'sh000002, 21'sh000005, 20'h00002);
    src.pulse(1'b1, 1'b0);
    src.pulse(1'b1, 1'b0);
    chk(pa, 22'h000002);
    chk({o1, o2}, 22'h000003);
    repeat (10) @(posedge clk);
    chk({o1, o2}, 22'h000000);
    src.level(1'b1, 1'b0);
    src.pulse(1'b1, 1'b0);
    chk(pa, 22'h000000);
    src.level(1'b0, 1'b0);
    src.pulse(1'b1, 1'b0);
    src.pulse(1'b1, 1'b0);
    src.level(1'b1, 1'b0);
    chk({o1, o2}, 22'h000000);
    src.level(1'b0, 1'b0);
    $display("oneshot test done");
  endtask

  task automatic t_total();
    cfg(mpc_pkg::CFG_TOTAL, 1'b0, 1'b0);
    repeat (3) src.pulse(1'b1, 1'b0);
    chk(tot, 22'h000003);
    src.level(1'b1, 1'b0);
    src.level(1'b0, 1'b0);
    src.pulse(1'b1, 1'b0);
    chk(pa, 22'h000001);
    chk(tot, 22'h000004);
    src.level(1'b0, 1'b1);
    chk(tot, 22'h000000);
    src.level(1'b0, 1'b0);
    src.pulse(1'b1, 1'b0);
    display_sel <= mpc_pkg::DSP_TOTAL;
    src.press();
    chk(tot, 22'h000000);
    chk(pa, 22'h000000);
    $display("total test done");
  endtask

  task automatic t_batch();
    cfg(mpc_pkg::CFG_BATCH, 1'b0, 1'b0);
    load(21'sh000001, 21'sh000001, 21'sh000005, 20'h00002);
    src.level(1'b1, 1'b1);
    src.level(1'b0, 1'b0);
    src.pulse(1'b1, 1'b0);
    chk(bat, 22'h000001);
    chk(o1, 22'h000000);
    src.level(1'b1, 1'b0);
    src.level(1'b0, 1'b0);
    src.pulse(1'b1, 1'b0);
    chk(bat, 22'h000002);
    chk(o1, 22'h000001);
    src.level(1'b0, 1'b1);
    chk({bat, o1}, 22'h000000);
    src.level(1'b1, 1'b0);
    src.level(1'b0, 1'b0);
    src.pulse(1'b1, 1'b0);
    display_sel <= mpc_pkg::DSP_BATCH;
    src.press();
    chk({bat, pa}, 22'h000000);
    src.pulse(1'b1, 1'b0);
    load(21'sh000001, 21'sh000001, 21'sh000005, 20'h00001);
    @(posedge clk);
    chk(o1, 22'h000001);
    load(21'sh000001, 21'sh000001, 21'sh000005, 20'h00003);
    chk(o1, 22'h000001);
    load(21'sh000001, 21'sh000001, 21'sh000005, 20'h00000);
    src.level(1'b0, 1'b1);
    src.level(1'b1, 1'b0);
    src.level(1'b0, 1'b0);
    src.pulse(1'b1, 1'b0);
    chk({bat, o1}, 22'h000002);
    $display("batch test done");
  endtask

  task automatic t_dual();
    cfg(mpc_pkg::CFG_DUAL, 1'b0, 1'b0);
    display_sel <= mpc_pkg::DSP_DUAL;
    src.press();
    src.pulse(1'b1, 1'b1);
    src.pulse(1'b1, 1'b1);
    chk({o1, o2}, 22'h000000);
    src.pulse(1'b1, 1'b0);
    chk(dual, 22'h000005);
    chk({o1, o2}, 22'h000003);
    cfg(mpc_pkg::CFG_DUAL, 1'b1, 1'b0);
    chk(dual, 22'h000001);
    src.level(1'b1, 1'b0);
    src.pulse(1'b0, 1'b1);
    chk(pb, 22'h000003);
    chk(dual, 22'h3FFFFD);
    src.level(1'b0, 1'b0);
    src.press();
    chk({pa, o1, o2}, 22'h000000);
    chk(pb, 22'h000000);
    chk(ovf, 22'h000000);
    $display("dual test done");
  endtask

  task automatic t_twin();
    cfg(mpc_pkg::CFG_TWIN, 1'b0, 1'b0);
    src.level(1'b1, 1'b1);
    src.level(1'b0, 1'b0);
    src.pulse(1'b1, 1'b0);
    src.pulse(1'b1, 1'b1);
    chk(pa, 22'h000002);
    chk(pb, 22'h000001);
    chk({o1, o2}, 22'h000003);
    src.level(1'b0, 1'b1);
    chk(pa, 22'h000002);
    chk(pb, 22'h000000);
    chk({o1, o2}, 22'h000002);
    src.level(1'b0, 1'b0);
    $display("twin test done");
  endtask

  task automatic t_misc();
    load(21'sh1E7960, 21'sh000002, 21'sh000005, 20'h00002);
    chk(rej, 22'h000001);
    load(21'sh1E7961, 21'sh0F423F, 21'sh000005, 20'h00002);
    chk(rej, 22'h000000);
    cfg(mpc_pkg::CFG_ONE, 1'b0, 1'b1);
    restore_first_control_output <= 1'b1;
    restore_second_control_output <= 1'b1;
    restore_pulse <= 1'b1;
    @(posedge clk);
    restore_pulse <= 1'b0;
    repeat (2) @(posedge clk);
    chk({o1, o2}, 22'h000003);
    repeat (12) @(posedge clk);
    chk({o1, o2}, 22'h000000);
    $display("misc test done");
  endtask

  initial begin
    settings = '{cfg: mpc_pkg::CFG_ONE, calc_sub: 1'b0, oneshot_en: 1'b0,
      oneshot_time: 14'h0001, backup_en: 1'b1};
    set_values = mpc_pkg::SETV_RESET;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_oneshot();
    t_total();
    t_batch();
    t_dual();
    t_twin();
    t_misc();
    close_out();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    close_out();
  end
endmodule // tb_top

`default_nettype wire
